// ### core/fpm_cfg.svh
// Constants of the front panel menu controller: timing, ranges, layouts.
// Assumes a 100 MHz system clock; included by bare name.
`ifndef FPM_CFG_SVH
`define FPM_CFG_SVH

// Clock and timing
`define FPM_CLK_HZ 100000000
`define FPM_TIMEOUT_S 30
`define FPM_TIMEOUT_CYC (64'd30 * 64'd100000000)
`define FPM_DEB_MS 10
`define FPM_DEB_CYC (`FPM_DEB_MS * (`FPM_CLK_HZ / 1000))
`define FPM_PHASE_MS 1000
`define FPM_PHASE_CYC (`FPM_PHASE_MS * (`FPM_CLK_HZ / 1000))

// Setting ranges (decimal and BCD) and reset values (BCD)
`define FPM_FREQ_MIN 1300
`define FPM_FREQ_MAX 2700
`define FPM_GAIN_MIN 0
`define FPM_GAIN_MAX 30
`define FPM_FREQ_LO_BCD 16'h1300
`define FPM_FREQ_HI_BCD 16'h2700
`define FPM_GAIN_HI_BCD 8'h30
`define FPM_FREQ_RST 16'h1300
`define FPM_GAIN_RST 8'h00

// Switch event indices
`define FPM_NEV 5
`define FPM_EV_MENU 0
`define FPM_EV_LEFT 1
`define FPM_EV_RIGHT 2
`define FPM_EV_UP 3
`define FPM_EV_DOWN 4

// Cursor return positions per screen
`define FPM_RET_FREQ 3'h4
`define FPM_RET_GAIN 3'h2
`define FPM_RET_TOG 3'h1

// Stored settings word layout
`define FPM_NV_W 26
`define FPM_NV_FREQ 15:0
`define FPM_NV_GAIN 23:16
`define FPM_NV_MUTE 24
`define FPM_NV_REM 25

`endif

// ### core/fpm_pkg.sv
// Types of the front panel menu controller.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package fpm_pkg;
  // Controller sequence
  typedef enum logic [2:0] {ST_LOAD, ST_SEGS, ST_VER, ST_IDLE, ST_EDIT, ST_SAVE} fpm_state_t;
  // Menu items in fixed order
  typedef enum logic [1:0] {IT_FREQ, IT_GAIN, IT_MUTE, IT_REMOTE} fpm_item_t;
  // Display phase
  typedef enum logic [1:0] {PH_BLANK, PH_SEGS, PH_VER, PH_RUN} fpm_phase_t;
endpackage

`default_nettype wire

// ### core/fpm_sw_if.sv
// Switch event bus between debouncer and menu logic.
// Assumes events are one-cycle pulses on clk_sys.
`include "fpm_cfg.svh"
`default_nettype none

interface fpm_sw_if;
  logic [`FPM_NEV-1:0] ev;
  modport src (output ev);
  modport dst (input ev);
endinterface

`default_nettype wire

// ### core/fpm_debounce.sv
// Per-switch synchroniser and debouncer producing one pulse per press.
// Assumes active-low switch pins asynchronous to clk_sys.
`include "fpm_cfg.svh"
`default_nettype none

module fpm_debounce import fpm_pkg::*; #(
  parameter int N = `FPM_NEV,
  parameter int DEB_CYC = `FPM_DEB_CYC
) (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // Raw switches, low when pressed
  input wire logic [N-1:0] sw_n,
  // Press events
  fpm_sw_if.src evb
);
  localparam int CW = $clog2(DEB_CYC + 1);

  if (N < 1 || DEB_CYC < 2) begin : g_bad
    $error("fpm_debounce: bad parameters");
  end

  wire logic [N-1:0] hit;

  ////////////////////////////////////////////////////////////////////////
  for (genvar i = 0; i < N; i++) begin : g_sw
    logic s1_reg, s2_reg, stb_reg, pls_reg;
    logic [CW-1:0] cnt_reg;
    wire logic raw_on = ~s2_reg;
    wire logic differ = raw_on != stb_reg;
    wire logic settled = differ && (cnt_reg == CW'(DEB_CYC - 1));
    // Sync, then accept a level only after it held DEB_CYC cycles
    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        s1_reg <= 1'b1;
        s2_reg <= 1'b1;
        stb_reg <= 1'b0;
        pls_reg <= 1'b0;
        cnt_reg <= '0;
      end else if (ce) begin
        s1_reg <= sw_n[i];
        s2_reg <= s1_reg;
        cnt_reg <= (differ && !settled) ? cnt_reg + 1'b1 : '0;
        if (settled) stb_reg <= raw_on;
        pls_reg <= settled && raw_on;
      end
    end
    assign hit[i] = pls_reg;
  end

  assign evb.ev = hit;
endmodule

`default_nettype wire

// ### core/fpm_bcd_step.sv
// Steps one decimal digit of a BCD value up or down, clamped to a range.
// Assumes the input holds valid BCD digits; purely combinational.
`include "fpm_cfg.svh"
`default_nettype none

module fpm_bcd_step import fpm_pkg::*; #(
  parameter int ND = 4,
  parameter int VMIN = `FPM_FREQ_MIN,
  parameter int VMAX = `FPM_FREQ_MAX
) (
  // Value and digit position, 0 is the most significant digit
  input wire logic [4*ND-1:0] val,
  input wire logic [2:0] pos,
  // Step requests
  input wire logic up,
  input wire logic dn,
  // Result
  output var logic [4*ND-1:0] res
);
  if (ND < 1 || ND > 8 || VMIN > VMAX) begin : g_bad
    $error("fpm_bcd_step: bad parameters");
  end

  function automatic int to_bin(input logic [4*ND-1:0] v);
    int acc;
    acc = 0;
    for (int i = ND - 1; i >= 0; i--) acc = acc * 10 + int'(v[4*i+:4]);
    return acc;
  endfunction

  function automatic logic [4*ND-1:0] to_bcd(input int x);
    logic [4*ND-1:0] r;
    int t;
    r = '0;
    t = x;
    for (int i = 0; i < ND; i++) begin
      r[4*i+:4] = 4'(t % 10);
      t = t / 10;
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Weight of the selected digit, then the clamped sum
  always_comb begin
    int w;
    int nv;
    w = 1;
    nv = 0;
    for (int i = 0; i < ND - 1; i++) if (i < ND - 1 - int'(pos)) w = w * 10;
    nv = to_bin(val) + (up ? w : 0) - (dn ? w : 0);
    if (nv > VMAX) nv = VMAX;
    if (nv < VMIN) nv = VMIN;
    res = (up || dn) ? to_bcd(nv) : val;
  end
endmodule

`default_nettype wire

// ### core/fpm_menu.sv
// Front panel menu controller: power-up display sequence, switch-driven
// editing of frequency, gain, mute and remote, save prompt and timeout.
// Assumes a power-on reset, a settings store that presents its word once
// after reset, and PLL lock lines and switch pins asynchronous to clk_sys.
`include "fpm_cfg.svh"
`default_nettype none

// How it works
// - Saved settings reload from store after power-up
// - Power-up shows segments, version, then settings
// - Sessions open and close with commit switch
// - Horizontal switch moves cursor left or right
// - Vertical switch steps digit under cursor
// - Vertical switch inverts on/off functions
// - Thirty seconds idle discards edits, back normal
// - Commit on a value steps to next item, on remote opens save prompt
// - Commit on return position opens save prompt
// - Yes stores settings, no restores old ones
// - Frequency reaches hardware only after yes
// - Gain applies live, stored only on yes
// - Gain steps ten or one dB by cursor
// - Any PLL unlock raises the alarm
// - Mute LED follows mute setting
// - Remote LED follows remote setting
// - Gain spans 0 to 30 dB decimal
// - Frequency spans 1300 to 2700 MHz decimal
module fpm_menu import fpm_pkg::*; #(
  parameter int NPLL = 2,
  parameter int DEB_CYC = `FPM_DEB_CYC,
  parameter int PHASE_CYC = `FPM_PHASE_CYC,
  parameter logic [31:0] TIMEOUT_CYC = 32'(`FPM_TIMEOUT_CYC),
  parameter logic [15:0] FW_VERSION = 16'h0101 // Arbitrary value
) (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // Front panel switches, low when pressed
  input wire logic sw_menu_n,
  input wire logic sw_left_n,
  input wire logic sw_right_n,
  input wire logic sw_up_n,
  input wire logic sw_down_n,
  // PLL lock indications, high when locked
  input wire logic [NPLL-1:0] pll_locked,
  // Settings store
  input wire logic nv_rd_valid,
  input wire logic [`FPM_NV_W-1:0] nv_rd_data,
  output var logic nv_wr_en,
  output var logic [`FPM_NV_W-1:0] nv_wr_data,
  // Converter settings
  output var logic [15:0] freq_bcd,
  output var logic [7:0] gain_bcd,
  output var logic mute_on,
  output var logic remote_on,
  // Indicators
  output var logic alarm_out,
  output var logic alarm_led,
  output var logic mute_led,
  output var logic remote_led,
  // Display
  output var fpm_phase_t lcd_phase,
  output var fpm_item_t lcd_item,
  output var logic [2:0] lcd_cursor,
  output var logic [15:0] lcd_freq,
  output var logic [7:0] lcd_gain,
  output var logic lcd_mute,
  output var logic lcd_remote,
  output var logic lcd_prompt,
  output var logic lcd_yes,
  output var logic [15:0] lcd_version
);
  if (NPLL < 1 || PHASE_CYC < 1 || TIMEOUT_CYC < 32'h1 || DEB_CYC < 2) begin : g_bad
    $error("fpm_menu: bad parameters");
  end

  ////////////////////////////////////////////////////////////////////////
  // State
  fpm_state_t state_reg, state_next;
  fpm_item_t item_reg, item_next;
  logic [2:0] cur_reg, cur_next;
  logic [31:0] ph_reg, ph_next;
  logic [31:0] to_reg, to_next;
  logic yes_reg, yes_next;
  logic nvw_reg, nvw_next;
  // Saved settings and the working copy
  logic [15:0] sav_f_reg, sav_f_next, ed_f_reg, ed_f_next;
  logic [7:0] sav_g_reg, sav_g_next, ed_g_reg, ed_g_next;
  logic sav_m_reg, sav_m_next, ed_m_reg, ed_m_next;
  logic sav_r_reg, sav_r_next, ed_r_reg, ed_r_next;
  // PLL lock synchroniser and alarm
  logic [NPLL-1:0] pll_s1_reg, pll_s2_reg;
  logic alarm_reg;

  ////////////////////////////////////////////////////////////////////////
  // Switch events
  fpm_sw_if sw_bus ();

  wire logic [`FPM_NEV-1:0] sw_raw_n = {sw_down_n, sw_up_n, sw_right_n, sw_left_n, sw_menu_n};

  fpm_debounce #(
    .N(`FPM_NEV),
    .DEB_CYC(DEB_CYC)
  ) u_deb (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .sw_n(sw_raw_n),
    .evb(sw_bus.src)
  );

  // Event decode
  wire logic ev_menu = sw_bus.ev[`FPM_EV_MENU];
  wire logic ev_left = sw_bus.ev[`FPM_EV_LEFT];
  wire logic ev_right = sw_bus.ev[`FPM_EV_RIGHT];
  wire logic ev_up = sw_bus.ev[`FPM_EV_UP];
  wire logic ev_down = sw_bus.ev[`FPM_EV_DOWN];
  wire logic ev_vert = ev_up || ev_down;
  wire logic ev_any = |sw_bus.ev;

  ////////////////////////////////////////////////////////////////////////
  // Cursor geometry of the current screen
  wire logic [2:0] cur_ret = (item_reg == IT_FREQ) ? `FPM_RET_FREQ :
                             (item_reg == IT_GAIN) ? `FPM_RET_GAIN : `FPM_RET_TOG;
  wire logic on_ret = cur_reg == cur_ret;
  wire logic in_edit = state_reg == ST_EDIT;
  wire logic dig_ok = in_edit && !on_ret && !ev_menu && !ev_left && !ev_right;
  wire logic f_up = dig_ok && (item_reg == IT_FREQ) && ev_up;
  wire logic f_dn = dig_ok && (item_reg == IT_FREQ) && ev_down;
  wire logic g_up = dig_ok && (item_reg == IT_GAIN) && ev_up;
  wire logic g_dn = dig_ok && (item_reg == IT_GAIN) && ev_down;
  wire logic timed_out = to_reg == TIMEOUT_CYC - 32'h1;
  wire logic phase_done = ph_reg == 32'(PHASE_CYC - 1);

  // Digit steppers
  logic [15:0] f_res;
  logic [7:0] g_res;

  fpm_bcd_step #(
    .ND(4),
    .VMIN(`FPM_FREQ_MIN),
    .VMAX(`FPM_FREQ_MAX)
  ) u_fstep (
    .val(ed_f_reg),
    .pos(cur_reg),
    .up(f_up),
    .dn(f_dn),
    .res(f_res)
  );

  fpm_bcd_step #(
    .ND(2),
    .VMIN(`FPM_GAIN_MIN),
    .VMAX(`FPM_GAIN_MAX)
  ) u_gstep (
    .val(ed_g_reg),
    .pos(cur_reg),
    .up(g_up),
    .dn(g_dn),
    .res(g_res)
  );

  ////////////////////////////////////////////////////////////////////////
  // Validation of the stored word
  function automatic logic bcd_ok(input logic [15:0] v);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 4; i++) if (v[4*i+:4] > 4'h9) ok = 1'b0;
    return ok;
  endfunction

  wire logic [15:0] nv_f = nv_rd_data[`FPM_NV_FREQ];
  wire logic [7:0] nv_g = nv_rd_data[`FPM_NV_GAIN];
  wire logic nv_f_ok = bcd_ok(nv_f) && nv_f >= `FPM_FREQ_LO_BCD && nv_f <= `FPM_FREQ_HI_BCD;
  wire logic nv_g_ok = bcd_ok({8'h00, nv_g}) && nv_g <= `FPM_GAIN_HI_BCD;
  wire logic [15:0] ld_f = nv_f_ok ? nv_f : `FPM_FREQ_RST;
  wire logic [7:0] ld_g = nv_g_ok ? nv_g : `FPM_GAIN_RST;

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic of the menu sequence
  always_comb begin
    state_next = state_reg;
    item_next = item_reg;
    cur_next = cur_reg;
    ph_next = ph_reg;
    to_next = to_reg;
    yes_next = yes_reg;
    nvw_next = 1'b0;
    sav_f_next = sav_f_reg;
    sav_g_next = sav_g_reg;
    sav_m_next = sav_m_reg;
    sav_r_next = sav_r_reg;
    ed_f_next = ed_f_reg;
    ed_g_next = ed_g_reg;
    ed_m_next = ed_m_reg;
    ed_r_next = ed_r_reg;
    unique case (state_reg)
      ST_LOAD: begin
        if (nv_rd_valid) begin
          sav_f_next = ld_f;
          sav_g_next = ld_g;
          sav_m_next = nv_rd_data[`FPM_NV_MUTE];
          sav_r_next = nv_rd_data[`FPM_NV_REM];
          ed_f_next = ld_f;
          ed_g_next = ld_g;
          ed_m_next = nv_rd_data[`FPM_NV_MUTE];
          ed_r_next = nv_rd_data[`FPM_NV_REM];
          ph_next = '0;
          state_next = ST_SEGS;
        end
      end
      ST_SEGS: begin
        ph_next = phase_done ? '0 : ph_reg + 32'h1;
        if (phase_done) state_next = ST_VER;
      end
      ST_VER: begin
        ph_next = phase_done ? '0 : ph_reg + 32'h1;
        if (phase_done) state_next = ST_IDLE;
      end
      ST_IDLE: begin
        // Only the commit switch is heard outside a session
        if (ev_menu) begin
          state_next = ST_EDIT;
          item_next = IT_FREQ;
          cur_next = '0;
          to_next = '0;
        end
      end
      ST_EDIT: begin
        to_next = ev_any ? '0 : to_reg + 32'h1;
        if (timed_out && !ev_any) begin
          ed_f_next = sav_f_reg;
          ed_g_next = sav_g_reg;
          ed_m_next = sav_m_reg;
          ed_r_next = sav_r_reg;
          state_next = ST_IDLE;
        end else if (ev_menu) begin
          cur_next = '0;
          if (on_ret || item_reg == IT_REMOTE) begin
            state_next = ST_SAVE;
            yes_next = 1'b0;
          end else begin
            item_next = fpm_item_t'(item_reg + 2'h1);
          end
        end else if (ev_left) begin
          if (cur_reg != 3'h0) cur_next = cur_reg - 3'h1;
        end else if (ev_right) begin
          if (!on_ret) cur_next = cur_reg + 3'h1;
        end else if (ev_vert && !on_ret) begin
          unique case (item_reg)
            IT_FREQ: ed_f_next = f_res;
            IT_GAIN: ed_g_next = g_res;
            IT_MUTE: ed_m_next = !ed_m_reg;
            IT_REMOTE: ed_r_next = !ed_r_reg;
          endcase
        end
      end
      ST_SAVE: begin
        to_next = ev_any ? '0 : to_reg + 32'h1;
        if (timed_out && !ev_any) begin
          ed_f_next = sav_f_reg;
          ed_g_next = sav_g_reg;
          ed_m_next = sav_m_reg;
          ed_r_next = sav_r_reg;
          state_next = ST_IDLE;
        end else if (ev_menu) begin
          state_next = ST_IDLE;
          if (yes_reg) begin
            sav_f_next = ed_f_reg;
            sav_g_next = ed_g_reg;
            sav_m_next = ed_m_reg;
            sav_r_next = ed_r_reg;
            nvw_next = 1'b1;
          end else begin
            ed_f_next = sav_f_reg;
            ed_g_next = sav_g_reg;
            ed_m_next = sav_m_reg;
            ed_r_next = sav_r_reg;
          end
        end else if (ev_vert) begin
          yes_next = !yes_reg;
        end
      end
      default: state_next = ST_LOAD;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequence registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg <= ST_LOAD;
      item_reg <= IT_FREQ;
      cur_reg <= '0;
      ph_reg <= '0;
      to_reg <= '0;
      yes_reg <= 1'b0;
      nvw_reg <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      item_reg <= item_next;
      cur_reg <= cur_next;
      ph_reg <= ph_next;
      to_reg <= to_next;
      yes_reg <= yes_next;
      nvw_reg <= nvw_next;
    end
  end

  // Settings registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sav_f_reg <= `FPM_FREQ_RST;
      sav_g_reg <= `FPM_GAIN_RST;
      sav_m_reg <= 1'b0;
      sav_r_reg <= 1'b0;
      ed_f_reg <= `FPM_FREQ_RST;
      ed_g_reg <= `FPM_GAIN_RST;
      ed_m_reg <= 1'b0;
      ed_r_reg <= 1'b0;
    end else if (ce) begin
      sav_f_reg <= sav_f_next;
      sav_g_reg <= sav_g_next;
      sav_m_reg <= sav_m_next;
      sav_r_reg <= sav_r_next;
      ed_f_reg <= ed_f_next;
      ed_g_reg <= ed_g_next;
      ed_m_reg <= ed_m_next;
      ed_r_reg <= ed_r_next;
    end
  end

  // PLL lock sampling; any unlocked loop raises the alarm
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pll_s1_reg <= '1;
      pll_s2_reg <= '1;
      alarm_reg <= 1'b0;
    end else if (ce) begin
      pll_s1_reg <= pll_locked;
      pll_s2_reg <= pll_s1_reg;
      alarm_reg <= !(&pll_s2_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Converter and store outputs
  assign freq_bcd = sav_f_reg;
  assign gain_bcd = ed_g_reg;
  assign mute_on = ed_m_reg;
  assign remote_on = ed_r_reg;
  assign nv_wr_en = nvw_reg;
  assign nv_wr_data = {sav_r_reg, sav_m_reg, sav_g_reg, sav_f_reg};

  // Indicators
  assign alarm_out = alarm_reg;
  assign alarm_led = alarm_reg;
  assign mute_led = ed_m_reg;
  assign remote_led = ed_r_reg;

  // Display
  assign lcd_phase = (state_reg == ST_LOAD) ? PH_BLANK :
                     (state_reg == ST_SEGS) ? PH_SEGS :
                     (state_reg == ST_VER) ? PH_VER : PH_RUN;
  assign lcd_item = item_reg;
  assign lcd_cursor = cur_reg;
  assign lcd_freq = ed_f_reg;
  assign lcd_gain = ed_g_reg;
  assign lcd_mute = ed_m_reg;
  assign lcd_remote = ed_r_reg;
  assign lcd_prompt = state_reg == ST_SAVE;
  assign lcd_yes = yes_reg;
  assign lcd_version = FW_VERSION;
endmodule

`default_nettype wire

// ### testbench/fpm_store_model.sv
// Settings store model: holds one saved word and presents it after reset.
// Assumes the controller samples the word only while it waits to load.
`include "fpm_cfg.svh"
`default_nettype none

module fpm_store_model #(
  parameter logic [`FPM_NV_W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Write side
  input wire logic nv_wr_en,
  input wire logic [`FPM_NV_W-1:0] nv_wr_data,
  // Read side
  output logic nv_rd_valid,
  output logic [`FPM_NV_W-1:0] nv_rd_data,
  output logic [`FPM_NV_W-1:0] stored
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [`FPM_NV_W-1:0] mem_reg = INIT;
  logic vld_reg = 1'b0;

  // Word survives reset; writes only on the strobe
  always @(posedge clk_sys) begin
    vld_reg <= rst_n;
    if (nv_wr_en) begin
      mem_reg <= nv_wr_data;
    end
  end

  // Data is scrambled while the word is not presented
  assign nv_rd_valid = vld_reg;
  assign nv_rd_data = vld_reg ? mem_reg : ~mem_reg;
  assign stored = mem_reg;
endmodule

`default_nettype wire

// ### testbench/fpm_menu_asserts.sv
// Port checker of the menu controller, bound to every fpm_menu.
// Assumes the clock enable is held high while checked.
`include "fpm_cfg.svh"
`default_nettype none

module fpm_menu_asserts import fpm_pkg::*; #(
  parameter int NPLL = 2,
  parameter int PHASE_CYC = 3
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Lock lines
  input wire logic [NPLL-1:0] pll_locked,
  // Store and settings
  input wire logic nv_wr_en,
  input wire logic [`FPM_NV_W-1:0] nv_wr_data,
  input wire logic [15:0] freq_bcd,
  input wire logic [7:0] gain_bcd,
  input wire logic mute_on,
  input wire logic remote_on,
  // Indicators and display
  input wire logic alarm_out,
  input wire logic alarm_led,
  input wire logic mute_led,
  input wire logic remote_led,
  input wire fpm_phase_t lcd_phase,
  input wire logic [15:0] lcd_freq,
  input wire logic [7:0] lcd_gain,
  input wire logic lcd_prompt
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////////
  // Power-up display phases
  a_phase_seq: assert property ($past(lcd_phase) == PH_BLANK && lcd_phase == PH_SEGS
    |-> ##PHASE_CYC lcd_phase == PH_VER ##PHASE_CYC lcd_phase == PH_RUN)
    else $error("power-up phases out of order");

  // Indicators
  a_mute_led: assert property (mute_led == mute_on)
    else $error("mute led differs from mute");
  a_remote_led: assert property (remote_led == remote_on)
    else $error("remote led differs from remote");
  a_alarm_sync: assert property ((!(&pll_locked)) [*4] |-> alarm_out)
    else $error("unlock without alarm");
  a_alarm_led: assert property (alarm_led == alarm_out)
    else $error("alarm led differs from alarm");

  // Settings and store
  a_freq_hold: assert property ($past(lcd_phase) == PH_RUN && $changed(freq_bcd) |-> nv_wr_en)
    else $error("frequency applied without save");
  a_wr_pulse: assert property (nv_wr_en |=> !nv_wr_en)
    else $error("store write longer than one cycle");
  a_wr_prompt: assert property (nv_wr_en |-> $past(lcd_prompt) && !lcd_prompt
    && nv_wr_data[15:0] == freq_bcd && nv_wr_data[23:16] == gain_bcd)
    else $error("store write outside prompt or wrong word");
  a_gain_live: assert property (gain_bcd == lcd_gain)
    else $error("gain not applied live");
  a_gain_range: assert property (gain_bcd <= 8'h30 && gain_bcd[3:0] <= 4'h9)
    else $error("gain out of range");
  a_freq_range: assert property (lcd_freq >= 16'h1300 && lcd_freq <= 16'h2700)
    else $error("frequency out of range");

  // Main scenarios
  c_save: cover property (nv_wr_en);
  c_prompt: cover property ($rose(lcd_prompt));
  c_alarm: cover property ($rose(alarm_out));
endmodule

bind fpm_menu fpm_menu_asserts #(.NPLL(NPLL), .PHASE_CYC(PHASE_CYC)) fpm_menu_asserts_i (
  .clk_sys(clk_sys), .rst_n(rst_n), .pll_locked(pll_locked), .nv_wr_en(nv_wr_en),
  .nv_wr_data(nv_wr_data), .freq_bcd(freq_bcd), .gain_bcd(gain_bcd), .mute_on(mute_on),
  .remote_on(remote_on), .alarm_out(alarm_out), .alarm_led(alarm_led), .mute_led(mute_led),
  .remote_led(remote_led), .lcd_phase(lcd_phase), .lcd_freq(lcd_freq), .lcd_gain(lcd_gain),
  .lcd_prompt(lcd_prompt));

`default_nettype wire

// ### testbench/tb_top.sv
// Self-checking bench of the menu controller, switches pressed by tasks.
// Assumes shortened debounce, phase and idle-timeout counts.
`include "fpm_cfg.svh"
`default_nettype none

module tb_top import fpm_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int DEB = 4;
  localparam int PH = 3;
  localparam int TMO = 50;
  localparam int M = 0, L = 1, R = 2, U = 3, D = 4;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [4:0] sw_n = 5'h1f;
  logic [1:0] pll_locked = 2'h3;
  logic nv_rd_valid, nv_wr_en, mute_on, remote_on, alarm_out, alarm_led;
  logic mute_led, remote_led, lcd_prompt, lcd_yes, lcd_mute, lcd_remote;
  logic [`FPM_NV_W-1:0] nv_rd_data, nv_wr_data, stored;
  logic [15:0] freq_bcd, lcd_freq, lcd_version;
  logic [7:0] gain_bcd, lcd_gain;
  logic [2:0] lcd_cursor;
  fpm_phase_t lcd_phase;
  fpm_item_t lcd_item;
  int bad_count = 0;
  int checks_done = 0;

  // Clock
  always #5 clk_sys = ~clk_sys;

  fpm_menu #(.DEB_CYC(DEB), .PHASE_CYC(PH), .TIMEOUT_CYC(32'd50)) fpm_menu_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .sw_menu_n(sw_n[M]), .sw_left_n(sw_n[L]),
    .sw_right_n(sw_n[R]), .sw_up_n(sw_n[U]), .sw_down_n(sw_n[D]), .pll_locked(pll_locked),
    .nv_rd_valid(nv_rd_valid), .nv_rd_data(nv_rd_data), .nv_wr_en(nv_wr_en),
    .nv_wr_data(nv_wr_data), .freq_bcd(freq_bcd), .gain_bcd(gain_bcd), .mute_on(mute_on),
    .remote_on(remote_on), .alarm_out(alarm_out), .alarm_led(alarm_led),
    .mute_led(mute_led), .remote_led(remote_led), .lcd_phase(lcd_phase),
    .lcd_item(lcd_item), .lcd_cursor(lcd_cursor), .lcd_freq(lcd_freq),
    .lcd_gain(lcd_gain), .lcd_mute(lcd_mute), .lcd_remote(lcd_remote),
    .lcd_prompt(lcd_prompt), .lcd_yes(lcd_yes), .lcd_version(lcd_version));

  fpm_store_model #(.INIT(26'h0122000)) fpm_store_model_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .nv_wr_en(nv_wr_en), .nv_wr_data(nv_wr_data),
    .nv_rd_valid(nv_rd_valid), .nv_rd_data(nv_rd_data), .stored(stored));

  ////////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic print_verdict;
    if (bad_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // One clean press and release of a switch
  task automatic press(input int i);
    @(posedge clk_sys);
    sw_n[i] <= 1'b0;
    repeat (DEB + 6) @(posedge clk_sys);
    sw_n[i] <= 1'b1;
    repeat (DEB + 6) @(posedge clk_sys);
  endtask

  // Bounded wait for load, then the display phases
  task automatic power_up;
    int n;
    n = 0;
    while (lcd_phase !== PH_SEGS) begin
      @(negedge clk_sys);
      n++;
      if (n > 100) begin
        bad_count++;
        print_verdict();
      end
    end
    repeat (PH) @(negedge clk_sys);
    check(lcd_phase, PH_VER);
    check(lcd_version, 16'h0101);
    repeat (PH) @(negedge clk_sys);
    check(lcd_phase, PH_RUN);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    power_up();
    check(freq_bcd, 16'h2000);
    check(gain_bcd, 8'h12);
    press(U);
    check(gain_bcd, 8'h12);
    // Session saved with yes
    press(M);
    press(U);
    check(lcd_freq, 16'h2700);
    check(freq_bcd, 16'h2000);
    press(D);
    check(lcd_freq, 16'h1700);
    press(R);
    check(lcd_cursor, 3'h1);
    press(U);
    check(lcd_freq, 16'h1800);
    press(L);
    press(D);
    check(lcd_freq, 16'h1300);
    press(M);
    check(lcd_item, IT_GAIN);
    press(U);
    check(gain_bcd, 8'h22);
    press(R);
    press(U);
    check(gain_bcd, 8'h23);
    press(L);
    press(U);
    check(gain_bcd, 8'h30);
    press(M);
    press(U);
    check(mute_led, 1'b1);
    check(lcd_mute, 1'b1);
    press(D);
    check(mute_on, 1'b0);
    press(M);
    press(D);
    check(remote_led, 1'b1);
    check(lcd_remote, 1'b1);
    press(M);
    check(lcd_prompt, 1'b1);
    press(U);
    check(lcd_yes, 1'b1);
    press(M);
    check(freq_bcd, 16'h1300);
    check(stored, 26'h2301300);
    // Session dropped with no from the return position
    press(M);
    press(M);
    press(D);
    check(gain_bcd, 8'h20);
    press(R);
    press(R);
    press(M);
    check(lcd_prompt, 1'b1);
    press(M);
    check(gain_bcd, 8'h30);
    check(stored, 26'h2301300);
    // Idle timeout abandons the edit
    press(M);
    press(U);
    check(lcd_freq, 16'h2300);
    repeat (TMO + 10) @(posedge clk_sys);
    check(lcd_freq, 16'h1300);
    press(U);
    check(lcd_freq, 16'h1300);
    // Loss of lock on one loop
    pll_locked <= 2'h2;
    repeat (5) @(posedge clk_sys);
    check(alarm_led, 1'b1);
    pll_locked <= 2'h3;
    repeat (5) @(posedge clk_sys);
    check(alarm_out, 1'b0);
    // Second power-up restores the saved word
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    check(lcd_phase, PH_BLANK);
    rst_n <= 1'b1;
    power_up();
    check(gain_bcd, 8'h30);
    check(remote_on, 1'b1);
    // A short bounce gives no event, a held press exactly one
    press(M);
    @(posedge clk_sys);
    sw_n[U] <= 1'b0;
    repeat (2) @(posedge clk_sys);
    sw_n[U] <= 1'b1;
    repeat (DEB + 6) @(posedge clk_sys);
    check(lcd_freq, 16'h1300);
    press(U);
    check(lcd_freq, 16'h2300);
    // A press while the clock enable is low leaves no trace
    ce <= 1'b0;
    press(D);
    check(lcd_freq, 16'h2300);
    ce <= 1'b1;
    press(D);
    check(lcd_freq, 16'h1300);
    print_verdict();
  end
endmodule

`default_nettype wire
